// [design/in_app_flash_programming.sv]
// in-application flash programming engine with its register file
`timescale 1ns/10ps
module in_app_flash_programming #(
  parameter int ENABLE_CYCLES = iap_pkg::ENABLE_WINDOW_CYCLES,
  parameter int ERASE_SHORT = iap_pkg::ERASE_SHORT_CYCLES,
  parameter int ERASE_LONG = iap_pkg::ERASE_LONG_CYCLES,
  parameter int WRITE_SHORT = iap_pkg::WRITE_SHORT_CYCLES,
  parameter int WRITE_LONG = iap_pkg::WRITE_LONG_CYCLES,
  parameter logic [15:0] PATTERN1 = 16'h1234,
  parameter logic [15:0] PATTERN2 = 16'h5678,
  parameter logic [15:0] PATTERN3 = 16'h9ABC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire iap_pkg::reg_req_t req_i,
  output logic [7:0] rdata_o,
  input wire logic [15:0] flash_rdata_i,
  output iap_pkg::flash_cmd_t flash_cmd_o,
  output logic cpu_halt_o
);

  localparam int TW = 22;

  // ----------------------------------------
  // reset release
  // ----------------------------------------
  logic [1:0] rst_sync;
  logic rst_n;

  // two-stage release of the asynchronous reset
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic enabled;
    logic [2:0] mode;
    logic trig;
    logic wstart;
    logic rden;
    logic rstart;
    logic [7:0] chip_reset_pattern;
    logic time_sel;
    logic clr;
    logic [12:0] addr;
    logic [3:0][15:0] data;
    iap_pkg::eng_state_t st;
    logic [4:0] idx;
    logic pdone;
    logic [7:0] rdata;
    iap_pkg::flash_cmd_t cmd;
    logic halt;
  } iap_state_t;

  iap_state_t cur;
  iap_state_t next_cur;

  logic buf_clear;
  logic buf_load;
  logic [15:0] buf_word;
  logic tmr_start;
  logic tmr_abort;
  logic [TW-1:0] tmr_count;
  logic tmr_done;

  // address decode shared by read and write paths
  function automatic logic hit(input iap_pkg::reg_req_t r, input logic [3:0] sel);
    hit = (r.sector == iap_pkg::SECTOR_ONE) && (r.sel == sel);
  endfunction

  // saturating word address step within a page
  function automatic logic [12:0] step_addr(input logic [12:0] a);
    if (a[4:0] == iap_pkg::LAST_OFFSET) begin
      step_addr = a;
    end else begin
      step_addr = a + 13'h0001;
    end
  endfunction

  // ----------------------------------------
  // register writes and operation engine
  // ----------------------------------------
  always_comb begin
    next_cur = cur;
    buf_clear = 1'b0;
    buf_load = 1'b0;
    tmr_start = 1'b0;
    tmr_abort = 1'b0;
    tmr_count = '0;
    next_cur.cmd.rd = 1'b0;
    next_cur.cmd.wr = 1'b0;
    next_cur.cmd.erase = 1'b0;

    // cpu register writes
    if (req_i.wr) begin
      if (hit(req_i, iap_pkg::REG_MAIN_CONTROL)) begin
        // software may clear but never set the enable status
        if (!req_i.wdata[iap_pkg::BIT_ENABLED_STATUS]) begin
          next_cur.enabled = 1'b0;
        end
        next_cur.mode = req_i.wdata[iap_pkg::BIT_MODE_HI:iap_pkg::BIT_MODE_LO];
        next_cur.rden = req_i.wdata[iap_pkg::BIT_READ_ENABLE];
        if (req_i.wdata[iap_pkg::BIT_ENABLE_TRIGGER] && !cur.trig) begin
          next_cur.trig = 1'b1;
          tmr_start = 1'b1;
          tmr_count = TW'(ENABLE_CYCLES);
          next_cur.st = iap_pkg::ST_WAIT;
        end
        if (req_i.wdata[iap_pkg::BIT_WRITE_START] && cur.st == iap_pkg::ST_IDLE
            && cur.enabled) begin
          next_cur.wstart = 1'b1;
        end
        if (req_i.wdata[iap_pkg::BIT_READ_START] && req_i.wdata[iap_pkg::BIT_READ_ENABLE]
            && cur.st == iap_pkg::ST_IDLE) begin
          next_cur.rstart = 1'b1;
        end
      end else if (hit(req_i, iap_pkg::REG_CHIP_RESET_PATTERN)) begin
        next_cur.chip_reset_pattern = req_i.wdata;
      end else if (hit(req_i, iap_pkg::REG_AUX_CONTROL)) begin
        next_cur.time_sel = req_i.wdata[iap_pkg::BIT_TIME_SELECT];
        if (req_i.wdata[iap_pkg::BIT_BUFFER_CLEAR] && cur.st == iap_pkg::ST_IDLE) begin
          next_cur.clr = 1'b1;
          next_cur.st = iap_pkg::ST_CLEAR;
        end
      end else if (hit(req_i, iap_pkg::REG_ADDRESS_LOW)) begin
        next_cur.addr[7:0] = req_i.wdata;
      end else if (hit(req_i, iap_pkg::REG_ADDRESS_HIGH)) begin
        next_cur.addr[12:8] = req_i.wdata[4:0];
      end else if (hit(req_i, iap_pkg::REG_DATA0_LOW)) begin
        next_cur.data[0][7:0] = req_i.wdata;
      end else if (hit(req_i, iap_pkg::REG_DATA0_HIGH)) begin
        next_cur.data[0][15:8] = req_i.wdata;
        if (cur.enabled) begin
          buf_load = 1'b1;
          next_cur.addr = step_addr(cur.addr);
        end
      end else if (hit(req_i, iap_pkg::REG_DATA1_LOW)) begin
        next_cur.data[1][7:0] = req_i.wdata;
      end else if (hit(req_i, iap_pkg::REG_DATA1_HIGH)) begin
        next_cur.data[1][15:8] = req_i.wdata;
      end else if (hit(req_i, iap_pkg::REG_DATA2_LOW)) begin
        next_cur.data[2][7:0] = req_i.wdata;
      end else if (hit(req_i, iap_pkg::REG_DATA2_HIGH)) begin
        next_cur.data[2][15:8] = req_i.wdata;
      end else if (hit(req_i, iap_pkg::REG_DATA3_LOW)) begin
        next_cur.data[3][7:0] = req_i.wdata;
      end else if (hit(req_i, iap_pkg::REG_DATA3_HIGH)) begin
        next_cur.data[3][15:8] = req_i.wdata;
      end
    end

    // launch of an activated operation from idle
    if (cur.st == iap_pkg::ST_IDLE && next_cur.st == iap_pkg::ST_IDLE) begin
      if (cur.rstart && cur.rden && cur.mode == iap_pkg::MODE_READ) begin
        next_cur.cmd.rd = 1'b1;
        next_cur.cmd.addr = cur.addr;
        next_cur.st = iap_pkg::ST_READ;
        next_cur.halt = 1'b1;
      end else if (cur.rstart) begin
        next_cur.rstart = 1'b0;
      end else if (cur.wstart && cur.enabled && cur.mode == iap_pkg::MODE_ERASE) begin
        next_cur.cmd.erase = 1'b1;
        next_cur.cmd.addr = {cur.addr[12:5], 5'h00};
        tmr_start = 1'b1;
        tmr_count = cur.time_sel ? TW'(ERASE_LONG) : TW'(ERASE_SHORT);
        next_cur.st = iap_pkg::ST_ERASE;
        next_cur.halt = 1'b1;
      end else if (cur.wstart && cur.enabled && cur.mode == iap_pkg::MODE_WRITE) begin
        next_cur.idx = 5'h00;
        next_cur.pdone = 1'b0;
        tmr_start = 1'b1;
        tmr_count = cur.time_sel ? TW'(WRITE_LONG) : TW'(WRITE_SHORT);
        next_cur.st = iap_pkg::ST_PROGRAM;
        next_cur.halt = 1'b1;
      end else if (cur.wstart) begin
        next_cur.wstart = 1'b0;
      end
    end

    // running operations
    case (cur.st)
      iap_pkg::ST_READ: begin
        next_cur.rdata = 8'h00;
        next_cur.data[0] = flash_rdata_i;
        next_cur.rstart = 1'b0;
        next_cur.halt = 1'b0;
        next_cur.st = iap_pkg::ST_IDLE;
      end
      iap_pkg::ST_ERASE: begin
        if (tmr_done) begin
          next_cur.wstart = 1'b0;
          next_cur.halt = 1'b0;
          next_cur.st = iap_pkg::ST_IDLE;
        end
      end
      iap_pkg::ST_PROGRAM: begin
        // one word per cycle across the whole page, then wait out the time
        if (!cur.pdone) begin
          next_cur.cmd.wr = 1'b1;
          next_cur.cmd.addr = {cur.addr[12:5], cur.idx};
          next_cur.cmd.wdata = buf_word;
          if (cur.cmd.wr) begin
            next_cur.idx = cur.idx + 5'h01;
            next_cur.cmd.addr = {cur.addr[12:5], cur.idx + 5'h01};
            // last slot issued: stop so the final word is not written again
            next_cur.pdone = (cur.idx == iap_pkg::LAST_OFFSET - 5'h01);
          end
        end
        if (tmr_done) begin
          next_cur.wstart = 1'b0;
          buf_clear = 1'b1;
          next_cur.halt = 1'b0;
          next_cur.cmd.wr = 1'b0;
          next_cur.st = iap_pkg::ST_IDLE;
        end
      end
      iap_pkg::ST_CLEAR: begin
        buf_clear = 1'b1;
        next_cur.clr = 1'b0;
        next_cur.st = iap_pkg::ST_IDLE;
      end
      iap_pkg::ST_WAIT: begin
        // patterns checked while the enable window is open
        if (cur.mode == iap_pkg::MODE_ENABLE && cur.data[1] == PATTERN1
            && cur.data[2] == PATTERN2 && cur.data[3] == PATTERN3) begin
          next_cur.enabled = 1'b1;
          next_cur.trig = 1'b0;
          tmr_abort = 1'b1;
          next_cur.st = iap_pkg::ST_IDLE;
        end else if (tmr_done) begin
          next_cur.trig = 1'b0;
          next_cur.st = iap_pkg::ST_IDLE;
        end
      end
      default: begin
      end
    endcase

    // register read data
    next_cur.rdata = 8'h00;
    if (req_i.rd) begin
      if (hit(req_i, iap_pkg::REG_MAIN_CONTROL)) begin
        next_cur.rdata = {cur.enabled, cur.mode, cur.trig, cur.wstart, cur.rden, cur.rstart};
      end else if (hit(req_i, iap_pkg::REG_CHIP_RESET_PATTERN)) begin
        next_cur.rdata = cur.chip_reset_pattern;
      end else if (hit(req_i, iap_pkg::REG_AUX_CONTROL)) begin
        next_cur.rdata = {6'h00, cur.time_sel, cur.clr};
      end else if (hit(req_i, iap_pkg::REG_ADDRESS_LOW)) begin
        next_cur.rdata = cur.addr[7:0];
      end else if (hit(req_i, iap_pkg::REG_ADDRESS_HIGH)) begin
        next_cur.rdata = {3'h0, cur.addr[12:8]};
      end else if (hit(req_i, iap_pkg::REG_DATA0_LOW)) begin
        next_cur.rdata = cur.data[0][7:0];
      end else if (hit(req_i, iap_pkg::REG_DATA0_HIGH)) begin
        next_cur.rdata = cur.data[0][15:8];
      end else if (hit(req_i, iap_pkg::REG_DATA1_LOW)) begin
        next_cur.rdata = cur.data[1][7:0];
      end else if (hit(req_i, iap_pkg::REG_DATA1_HIGH)) begin
        next_cur.rdata = cur.data[1][15:8];
      end else if (hit(req_i, iap_pkg::REG_DATA2_LOW)) begin
        next_cur.rdata = cur.data[2][7:0];
      end else if (hit(req_i, iap_pkg::REG_DATA2_HIGH)) begin
        next_cur.rdata = cur.data[2][15:8];
      end else if (hit(req_i, iap_pkg::REG_DATA3_LOW)) begin
        next_cur.rdata = cur.data[3][7:0];
      end else if (hit(req_i, iap_pkg::REG_DATA3_HIGH)) begin
        next_cur.rdata = cur.data[3][15:8];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '0;
      cur.st <= iap_pkg::ST_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // buffer and timer
  // ----------------------------------------
  iap_write_buffer #(
    .WORDS(iap_pkg::PAGE_WORDS),
    .IDX_BITS(iap_pkg::OFFSET_BITS)
  ) u_buffer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .clear_i(buf_clear),
    .load_i(buf_load),
    .load_idx_i(cur.addr[4:0]),
    .load_data_i({req_i.wdata, cur.data[0][7:0]}),
    .rd_idx_i(cur.cmd.wr ? cur.idx + 5'h01 : cur.idx),
    .rd_data_o(buf_word)
  );

  iap_delay_timer #(
    .WIDTH(TW)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n),
    .start_i(tmr_start),
    .abort_i(tmr_abort),
    .count_i(tmr_count),
    .done_o(tmr_done),
    .running_o()
  );

  assign rdata_o = cur.rdata;
  assign flash_cmd_o = cur.cmd;
  assign cpu_halt_o = cur.halt;

endmodule // in_app_flash_programming

// [design/iap_pkg.sv]
// constants, types and register map of the in-application programming engine
// Behaviour
// - erase and program whole 32-word pages, read single words
// - enable status bit 7 of main control goes high when enabling succeeds
// - write buffer accepts data only while enable status is high
// - write start bit 2 set by software, cleared by hardware when done
// - read needs read enable bit 1; read start bit 0 cleared when done
// - address bits 12 to 5 pick the page, bits 4 to 0 the word
// - buffer clear bit 0 of aux control cleared by hardware when done
// - low data byte write only stores; high byte write loads 16-bit word
// - each high byte write while enabled increments the word address and stores it back
// - offset stops at 11111b; software then loads a new page address
// - write buffer is cleared automatically after programming finishes
// - 13-bit address: high register low five bits, low register eight bits
// - registers sit in data sector 1, direct or indirect access
// - mode field bits 6 to 4: write, erase, read, enable; others reserved
// - enable trigger starts a timer, cleared on timeout; patterns before it
// - cpu is halted while an activated read, write or erase runs
package iap_pkg;

  // ----------------------------------------
  // register selects within data sector 1
  // ----------------------------------------
  localparam logic [3:0] REG_MAIN_CONTROL = 4'h0;
  localparam logic [3:0] REG_CHIP_RESET_PATTERN = 4'h1;
  localparam logic [3:0] REG_AUX_CONTROL = 4'h2;
  localparam logic [3:0] REG_ADDRESS_LOW = 4'h3;
  localparam logic [3:0] REG_ADDRESS_HIGH = 4'h4;
  localparam logic [3:0] REG_DATA0_LOW = 4'h5;
  localparam logic [3:0] REG_DATA0_HIGH = 4'h6;
  localparam logic [3:0] REG_DATA1_LOW = 4'h7;
  localparam logic [3:0] REG_DATA1_HIGH = 4'h8;
  localparam logic [3:0] REG_DATA2_LOW = 4'h9;
  localparam logic [3:0] REG_DATA2_HIGH = 4'hA;
  localparam logic [3:0] REG_DATA3_LOW = 4'hB;
  localparam logic [3:0] REG_DATA3_HIGH = 4'hC;
  localparam logic [7:0] SECTOR_ONE = 8'h01;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_ENABLED_STATUS = 7;
  localparam int BIT_MODE_HI = 6;
  localparam int BIT_MODE_LO = 4;
  localparam int BIT_ENABLE_TRIGGER = 3;
  localparam int BIT_WRITE_START = 2;
  localparam int BIT_READ_ENABLE = 1;
  localparam int BIT_READ_START = 0;
  localparam int BIT_BUFFER_CLEAR = 0;
  localparam int BIT_TIME_SELECT = 1;

  // ----------------------------------------
  // reset values and sizes
  // ----------------------------------------
  localparam logic [7:0] MAIN_CONTROL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int PAGE_WORDS = 32;
  localparam int ADDR_BITS = 13;
  localparam int OFFSET_BITS = 5;
  localparam logic [4:0] LAST_OFFSET = 5'h1F;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int ENABLE_WINDOW_US = 100;
  localparam int ENABLE_WINDOW_CYCLES = ENABLE_WINDOW_US * CLK_MHZ;
  localparam int ERASE_SHORT_US = 3200;
  localparam int ERASE_LONG_US = 3700;
  localparam int WRITE_SHORT_US = 2200;
  localparam int WRITE_LONG_US = 3000;
  localparam int ERASE_SHORT_CYCLES = ERASE_SHORT_US * CLK_MHZ;
  localparam int ERASE_LONG_CYCLES = ERASE_LONG_US * CLK_MHZ;
  localparam int WRITE_SHORT_CYCLES = WRITE_SHORT_US * CLK_MHZ;
  localparam int WRITE_LONG_CYCLES = WRITE_LONG_US * CLK_MHZ;

  // ----------------------------------------
  // operation modes and engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_WRITE = 3'b000,
    MODE_ERASE = 3'b001,
    MODE_READ = 3'b011,
    MODE_ENABLE = 3'b110
  } op_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ERASE = 3'b001,
    ST_PROGRAM = 3'b010,
    ST_READ = 3'b011,
    ST_CLEAR = 3'b100,
    ST_WAIT = 3'b101
  } eng_state_t;

  // cpu side register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] sector;
    logic [3:0] sel;
    logic [7:0] wdata;
  } reg_req_t;

  // flash array command
  typedef struct packed {
    logic rd;
    logic wr;
    logic erase;
    logic [12:0] addr;
    logic [15:0] wdata;
  } flash_cmd_t;

endpackage

// [design/iap_write_buffer.sv]
// 32-word write buffer of the programming engine
`timescale 1ns/10ps
module iap_write_buffer #(
  parameter int WORDS = 32,
  parameter int IDX_BITS = 5
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [IDX_BITS-1:0] load_idx_i,
  input wire logic [15:0] load_data_i,
  input wire logic [IDX_BITS-1:0] rd_idx_i,
  output logic [15:0] rd_data_o
);

  typedef struct packed {
    logic [WORDS-1:0][15:0] mem;
  } buf_state_t;

  buf_state_t cur;
  buf_state_t next_cur;

  // clear wins over load, erased flash reads as all ones
  always_comb begin
    next_cur = cur;
    if (clear_i) begin
      next_cur.mem = '1;
    end else if (load_i) begin
      next_cur.mem[load_idx_i] = load_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur <= '1;
    end else begin
      cur <= next_cur;
    end
  end

  assign rd_data_o = cur.mem[rd_idx_i];

endmodule // iap_write_buffer

// [design/iap_delay_timer.sv]
// down counter that flags the end of a timed operation
`timescale 1ns/10ps
module iap_delay_timer #(
  parameter int WIDTH = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [WIDTH-1:0] count_i,
  output logic done_o,
  output logic running_o
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
    logic run;
    logic done;
  } tmr_state_t;

  tmr_state_t cur;
  tmr_state_t next_cur;

  // load, count down, pulse done on reaching one
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    if (abort_i) begin
      next_cur.run = 1'b0;
    end else if (start_i) begin
      next_cur.cnt = count_i;
      next_cur.run = 1'b1;
    end else if (cur.run) begin
      if (cur.cnt <= WIDTH'(1)) begin
        next_cur.run = 1'b0;
        next_cur.done = 1'b1;
      end else begin
        next_cur.cnt = cur.cnt - WIDTH'(1);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign done_o = cur.done;
  assign running_o = cur.run;

endmodule // iap_delay_timer

// [testbench/in_app_flash_programming_asserts.sv]
// checker on the programming engine ports
`timescale 1ns/10ps
module in_app_flash_programming_asserts #(
  parameter int ERASE_LONG = 50,
  parameter int WRITE_LONG = 50
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire iap_pkg::reg_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire logic [15:0] flash_rdata_i,
  input wire iap_pkg::flash_cmd_t flash_cmd_o,
  input wire logic cpu_halt_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  // ----------------------------------------
  // helper counters
  // ----------------------------------------
  logic [5:0] wr_count;
  logic [12:0] last_addr;
  logic [31:0] halt_cnt;
  // words per busy period and busy length
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_count <= 6'h00;
      last_addr <= 13'h0000;
      halt_cnt <= 32'h0;
    end else begin
      if (!cpu_halt_o) begin
        wr_count <= 6'h00;
      end else if (flash_cmd_o.wr) begin
        wr_count <= wr_count + 6'h01;
      end
      if (flash_cmd_o.wr) begin
        last_addr <= flash_cmd_o.addr;
      end
      halt_cnt <= cpu_halt_o ? halt_cnt + 32'h1 : 32'h0;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  rd_pulse_a: assert property (flash_cmd_o.rd |=> !flash_cmd_o.rd)
    else $error("read pulse too long");
  erase_pulse_a: assert property (flash_cmd_o.erase |=> !flash_cmd_o.erase)
    else $error("erase pulse too long");
  busy_halt_a: assert property ((flash_cmd_o.wr || flash_cmd_o.erase) |-> cpu_halt_o)
    else $error("array busy without halt");
  rdata_idle_a: assert property (!req_i.rd |=> rdata_o == 8'h00)
    else $error("read data without read");
  cmd_onehot_a: assert property ($onehot0({flash_cmd_o.rd, flash_cmd_o.wr, flash_cmd_o.erase}))
    else $error("two array commands at once");
  page_words_a: assert property (flash_cmd_o.wr |-> wr_count < 6'h20)
    else $error("more than a page written");
  word_order_a: assert property (flash_cmd_o.wr && wr_count != 6'h00 |->
    flash_cmd_o.addr == last_addr + 13'h0001)
    else $error("program address out of order");
  first_word_a: assert property (flash_cmd_o.wr && wr_count == 6'h00 |->
    flash_cmd_o.addr[4:0] == 5'h00)
    else $error("program not from page start");
  full_page_a: assert property ($fell(cpu_halt_o) && wr_count != 6'h00 |->
    wr_count == 6'h20)
    else $error("program ended short of a page");
  halt_bound_a: assert property (int'(halt_cnt) < ERASE_LONG + WRITE_LONG + 100)
    else $error("busy never ends");
  cover property (flash_cmd_o.erase);
  cover property (flash_cmd_o.rd);
  cover property ($fell(cpu_halt_o) && wr_count == 6'h20);
endmodule // in_app_flash_programming_asserts

bind in_app_flash_programming in_app_flash_programming_asserts #(
  .ERASE_LONG(ERASE_LONG), .WRITE_LONG(WRITE_LONG)
) u_asserts (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req_i), .rdata_o(rdata_o),
  .flash_rdata_i(flash_rdata_i), .flash_cmd_o(flash_cmd_o), .cpu_halt_o(cpu_halt_o));

// [testbench/flash_array_model.sv]
// behavioural flash array behind the engine
`timescale 1ns/10ps
module flash_array_model (
  input wire logic sys_clk_i,
  input wire iap_pkg::flash_cmd_t cmd_i,
  output logic [15:0] rdata_o
);
  logic [15:0] mem [8192];
  logic [15:0] idle_q;
  // start contents are the word index
  initial begin
    for (int i = 0; i < 8192; i++) mem[i] = 16'(i);
    idle_q = 16'h0000;
  end
  // read word stands while the read pulse does, engine takes it at the pulse's end
  assign rdata_o = cmd_i.rd ? mem[cmd_i.addr] : idle_q;
  // page erase, word program; idle bus toggles
  always @(posedge sys_clk_i) begin
    idle_q <= ~idle_q;
    if (cmd_i.erase) begin
      for (int i = 0; i < 32; i++) mem[{cmd_i.addr[12:5], i[4:0]}] <= 16'hFFFF;
    end
    if (cmd_i.wr) mem[cmd_i.addr] <= cmd_i.wdata;
  end
endmodule // flash_array_model

// [testbench/in_app_flash_programming_tb.sv]
// self-checking bench of the programming engine
`timescale 1ns/10ps
module in_app_flash_programming_tb;
  localparam logic [15:0] PAT1 = 16'hA5C3;
  localparam logic [15:0] PAT2 = 16'h3C5A;
  localparam logic [15:0] PAT3 = 16'h0FF0;
  logic sys_clk_i;
  logic nrst_i;
  iap_pkg::reg_req_t req_i;
  logic [7:0] rdata_o;
  logic [15:0] flash_rdata_i;
  iap_pkg::flash_cmd_t flash_cmd_o;
  logic cpu_halt_o;
  logic [7:0] rd_val;
  int miscompares;
  int compares;
  int cycles;

  in_app_flash_programming #(.ENABLE_CYCLES(50), .ERASE_SHORT(40), .ERASE_LONG(48),
    .WRITE_SHORT(40), .WRITE_LONG(48), .PATTERN1(PAT1), .PATTERN2(PAT2), .PATTERN3(PAT3)
  ) DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .req_i(req_i), .rdata_o(rdata_o),
    .flash_rdata_i(flash_rdata_i), .flash_cmd_o(flash_cmd_o), .cpu_halt_o(cpu_halt_o));
  flash_array_model flash (.sys_clk_i(sys_clk_i), .cmd_i(flash_cmd_o), .rdata_o(flash_rdata_i));

  // ----------------------------------------
  // clock and hang guard
  // ----------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  // ----------------------------------------
  // access and compare tasks
  // ----------------------------------------
  task automatic reg_wr(input logic [3:0] sel, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    req_i = '{wr: 1'b1, rd: 1'b0, sector: iap_pkg::SECTOR_ONE, sel: sel, wdata: d};
    @(posedge sys_clk_i);
    #1;
    req_i = '0;
  endtask
  task automatic reg_rd(input logic [3:0] sel);
    @(posedge sys_clk_i);
    #1;
    req_i = '{wr: 1'b0, rd: 1'b1, sector: iap_pkg::SECTOR_ONE, sel: sel, wdata: 8'h00};
    @(posedge sys_clk_i);
    #1;
    req_i = '0;
    rd_val = rdata_o;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [3:0] sel, input logic [7:0] exp);
    reg_rd(sel);
    check({8'h00, rd_val}, {8'h00, exp});
  endtask
  task automatic wait_bit(input logic [3:0] sel, input int b, input logic v);
    for (int n = 0; n < 200; n++) begin
      reg_rd(sel);
      if (rd_val[b] === v) return;
    end
    check({15'h0000, rd_val[b]}, {15'h0000, v});
  endtask
  task automatic set_addr(input logic [7:0] hi, input logic [7:0] lo);
    reg_wr(iap_pkg::REG_ADDRESS_HIGH, hi);
    reg_wr(iap_pkg::REG_ADDRESS_LOW, lo);
  endtask
  task automatic load_word(input logic [15:0] w);
    reg_wr(iap_pkg::REG_DATA0_LOW, w[7:0]);
    reg_wr(iap_pkg::REG_DATA0_HIGH, w[15:8]);
  endtask
  task automatic page_chk(input logic [12:0] base, input logic all_ones);
    for (int i = 0; i < 32; i++) begin
      check(flash.mem[base + 13'(i)], all_ones ? 16'hFFFF : {8'(i), ~8'(i)});
    end
  endtask
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    for (int s = 0; s < 13; s++) rd_chk(4'(s), 8'h00);
  endtask
  task automatic t_refused();
    reg_wr(iap_pkg::REG_MAIN_CONTROL, 8'h80);
    rd_chk(iap_pkg::REG_MAIN_CONTROL, 8'h00);
    load_word(16'h1234);
    rd_chk(iap_pkg::REG_ADDRESS_LOW, 8'h00);
  endtask
  task automatic t_enable();
    reg_wr(iap_pkg::REG_MAIN_CONTROL, 8'h68);
    reg_wr(iap_pkg::REG_DATA1_LOW, PAT1[7:0]);
    reg_wr(iap_pkg::REG_DATA1_HIGH, PAT1[15:8]);
    reg_wr(iap_pkg::REG_DATA2_LOW, PAT2[7:0]);
    reg_wr(iap_pkg::REG_DATA2_HIGH, PAT2[15:8]);
    reg_wr(iap_pkg::REG_DATA3_LOW, PAT3[7:0]);
    reg_wr(iap_pkg::REG_DATA3_HIGH, PAT3[15:8]);
    wait_bit(iap_pkg::REG_MAIN_CONTROL, 7, 1'b1);
    wait_bit(iap_pkg::REG_MAIN_CONTROL, 3, 1'b0);
  endtask
  task automatic t_saturate();
    set_addr(8'h1F, 8'hFE);
    load_word(16'hBEEF);
    rd_chk(iap_pkg::REG_ADDRESS_LOW, 8'hFF);
    load_word(16'hCAFE);
    rd_chk(iap_pkg::REG_ADDRESS_LOW, 8'hFF);
    rd_chk(iap_pkg::REG_ADDRESS_HIGH, 8'h1F);
    reg_wr(iap_pkg::REG_MAIN_CONTROL, 8'hA4);
    rd_chk(iap_pkg::REG_MAIN_CONTROL, 8'hA0);
  endtask
  task automatic t_program(input logic load);
    reg_wr(iap_pkg::REG_AUX_CONTROL, 8'h01);
    wait_bit(iap_pkg::REG_AUX_CONTROL, 0, 1'b0);
    set_addr(8'h01, 8'h20);
    reg_wr(iap_pkg::REG_MAIN_CONTROL, 8'h94);
    wait_bit(iap_pkg::REG_MAIN_CONTROL, 2, 1'b0);
    page_chk(13'h0120, 1'b1);
    set_addr(8'h01, 8'h20);
    for (int i = 0; i < 32 && load; i++) load_word({8'(i), ~8'(i)});
    rd_chk(iap_pkg::REG_ADDRESS_LOW, load ? 8'h3F : 8'h20);
    reg_wr(iap_pkg::REG_MAIN_CONTROL, 8'h84);
    wait_bit(iap_pkg::REG_MAIN_CONTROL, 2, 1'b0);
    page_chk(13'h0120, !load);
  endtask
  task automatic t_read();
    set_addr(8'h01, 8'h25);
    reg_wr(iap_pkg::REG_MAIN_CONTROL, 8'hB3);
    wait_bit(iap_pkg::REG_MAIN_CONTROL, 0, 1'b0);
    rd_chk(iap_pkg::REG_DATA0_LOW, 8'hFA);
    rd_chk(iap_pkg::REG_DATA0_HIGH, 8'h05);
  endtask

  // main sequence
  initial begin
    nrst_i = 1'b0;
    req_i = '0;
    cycles = 0;
    miscompares = 0;
    compares = 0;
    repeat (4) @(posedge sys_clk_i);
    #1;
    nrst_i = 1'b1;
    repeat (2) @(posedge sys_clk_i);
    t_reset();
    t_refused();
    t_enable();
    t_saturate();
    t_program(1'b1);
    t_read();
    t_program(1'b0);
    results();
  end
endmodule // in_app_flash_programming_tb
